// *** hdl/ir_carrier_pkg.sv ***
// package: register map, field layout, reset values and timing constants of the remote ir bank
package ir_carrier_pkg;
    localparam logic [2:0] OFS_RX_BAND = 3'h0;
    localparam logic [2:0] OFS_TX_CARRIER = 3'h1;
    localparam logic [2:0] OFS_CONFIG = 3'h2;
    localparam logic [2:0] OFS_BANK_SELECT = 3'h3;
    localparam logic [2:0] OFS_FE_SELECT_ONE = 3'h4;
    localparam logic [2:0] OFS_FE_SELECT_TWO = 3'h5;
    localparam logic [2:0] OFS_FE_SELECT_THREE = 3'h6;
    localparam logic [2:0] OFS_MODULE_CONTROL = 3'h7;
    // flag-count register lives outside this bank; placed at an own index
    localparam logic [3:0] OFS_FLAG_COUNTS = 4'h8;
    localparam logic [3:0] BANK_ADDR_TOP = 4'h7;
    localparam logic [7:0] RST_RX_BAND = 8'h29;
    localparam logic [7:0] RST_TX_CARRIER = 8'h69;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_FE_SELECT = 8'h00;
    localparam logic [7:0] RST_MODULE_CONTROL = 8'h00;
    localparam logic [7:0] RST_FLAG_COUNTS = 8'h2A;
    localparam logic [7:0] BANK_SELECT_READ = 8'hF4;
    // field positions
    localparam int RANGE_LSB = 5;
    localparam int FREQ_LSB = 0;
    localparam int CODING_BIT = 7;
    localparam int RX_HIGH_BIT = 5;
    localparam int TX_HIGH_BIT = 3;
    localparam int MOD_LSB = 0;
    localparam int MEDIUM_LSB = 4;
    localparam int FAST_LSB = 0;
    // timing
    localparam int CLOCK_HZ = 10_000_000;
    localparam int CLOCK_KHZ = CLOCK_HZ / 1000;
    localparam int CARRIER_CNT_W = 10;
    localparam int BURST_CNT_W = 17;
    localparam int PULSE_CNT_W = 4;

    // register write/read request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // decoded settings that the carrier logic consumes
    typedef struct packed {
        logic codingEn;
        logic txHigh;
        logic rxHigh;
        logic [1:0] modSel;
        logic [2:0] widthSel;
        logic [4:0] txFreq;
        logic [2:0] rxRange;
        logic [4:0] rxFreq;
    } ir_cfg_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_BURST = 3'b010,
        TX_GAP = 3'b100
    } tx_state_t;

    // flag code to count; zero marks a reserved code
    function automatic logic [5:0] flag_count(input logic [3:0] code);
        logic [5:0] n;
        n = 6'h00;
        unique case (code)
            4'h1: n = 6'h01;
            4'h2: n = 6'h02;
            4'h3: n = 6'h03;
            4'h4: n = 6'h04;
            4'h5: n = 6'h05;
            4'h6: n = 6'h06;
            4'h7: n = 6'h08;
            4'h8: n = 6'h0A;
            4'h9: n = 6'h0C;
            4'hA: n = 6'h10;
            4'hB: n = 6'h14;
            4'hC: n = 6'h18;
            4'hD: n = 6'h1C;
            4'hE: n = 6'h20;
            default: n = 6'h00;
        endcase
        return n;
    endfunction : flag_count
endpackage : ir_carrier_pkg

// *** hdl/ir_carrier_and_flag_config.sv ***
// remote ir register bank, flag-count decode, carrier generator and carrier-period checker
// Summary of operation
// R1: flag codes 1-6 direct, 7-E to 8..32
// R2: medium-speed start flags reset to two
// R3: software keeps medium-speed flags at two+
// R4: fast preamble field resets to sixteen flags
// R5: software keeps fast preamble at sixteen
// R6: bank decodes eight offsets zero to seven
// R7: receiver passes carrier only inside chosen range
// R8: reset rx select 01001 accepts 33.6-38.1 kHz
// R9: low band ranges widen per range code
// R10: high band rx codes 00011, 01000, 01011
// R11: ask ranges 010-110 widen to 384-738.5
// R12: burst width codes 010-101 per band
// R13: low band tx carrier 30 to 56 kHz
// R14: high band tx carrier 400/450/480 kHz
// R15: config bit 7 enables pulse-number coding
// R16: bit 0 sends pulses, bit 1 silence
// R17: modulation: continuous, eight, six pulses
// R18: bank select write switches, reads F4
// R19: carrier and widths from loaded dividers
// R20: receiver measures carrier period by counter
module ir_carrier_and_flag_config
    import ir_carrier_pkg::*;
#(
    parameter int CLK_KHZ = CLOCK_KHZ
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic bankSwitch,
    output logic [7:0] bankSelectValue,
    // serial core side
    input wire logic txBit,
    input wire logic txBitValid,
    output logic [5:0] mediumFlagCount,
    output logic [5:0] fastFlagCount,
    output logic [7:0] frontEndSelectOne,
    output logic [7:0] frontEndSelectTwo,
    output logic [7:0] frontEndSelectThree,
    output logic [7:0] moduleControl,
    output logic rxBitValue,
    // transceiver pins
    input wire logic irRxPin,
    output logic irTxPin
);
    reg_req_t req;
    ir_cfg_t cfg;
    logic [7:0] rxBand_r, rxBand_nxt, txCarrier_r, txCarrier_nxt, config_r, config_nxt;
    logic [7:0] fe1_r, fe1_nxt, fe2_r, fe2_nxt, fe3_r, fe3_nxt, modCtl_r, modCtl_nxt;
    logic [7:0] flags_r, flags_nxt, rdata_r, rdata_nxt, bankVal_r, bankVal_nxt;
    logic bankSw_r, bankSw_nxt;

    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // register writes and read mux
    always_comb begin
        rxBand_nxt = rxBand_r;
        txCarrier_nxt = txCarrier_r;
        config_nxt = config_r;
        fe1_nxt = fe1_r;
        fe2_nxt = fe2_r;
        fe3_nxt = fe3_r;
        modCtl_nxt = modCtl_r;
        flags_nxt = flags_r;
        bankVal_nxt = bankVal_r;
        bankSw_nxt = 1'b0;
        rdata_nxt = 8'h00;
        if (req.wr) begin
            if (req.addr == OFS_FLAG_COUNTS) begin
                flags_nxt = req.wdata; // R1 R4
            end else if (req.addr <= BANK_ADDR_TOP) begin
                unique case (req.addr[2:0]) // R6
                    OFS_RX_BAND: rxBand_nxt = req.wdata;
                    OFS_TX_CARRIER: txCarrier_nxt = req.wdata;
                    OFS_CONFIG: config_nxt = req.wdata;
                    OFS_BANK_SELECT: begin
                        bankVal_nxt = req.wdata; // R18
                        bankSw_nxt = 1'b1;
                    end
                    OFS_FE_SELECT_ONE: fe1_nxt = req.wdata;
                    OFS_FE_SELECT_TWO: fe2_nxt = req.wdata;
                    OFS_FE_SELECT_THREE: fe3_nxt = req.wdata;
                    OFS_MODULE_CONTROL: modCtl_nxt = req.wdata;
                endcase
            end
        end
        if (req.rd) begin
            if (req.addr == OFS_FLAG_COUNTS) begin
                rdata_nxt = flags_r;
            end else if (req.addr <= BANK_ADDR_TOP) begin
                unique case (req.addr[2:0]) // R6
                    OFS_RX_BAND: rdata_nxt = rxBand_r;
                    OFS_TX_CARRIER: rdata_nxt = txCarrier_r;
                    OFS_CONFIG: rdata_nxt = config_r;
                    OFS_BANK_SELECT: rdata_nxt = BANK_SELECT_READ; // R18
                    OFS_FE_SELECT_ONE: rdata_nxt = fe1_r;
                    OFS_FE_SELECT_TWO: rdata_nxt = fe2_r;
                    OFS_FE_SELECT_THREE: rdata_nxt = fe3_r;
                    OFS_MODULE_CONTROL: rdata_nxt = modCtl_r;
                endcase
            end
        end
    end

    // register state
    always_ff @(posedge clock) begin
        if (rst) begin
            rxBand_r <= RST_RX_BAND; // R8
            txCarrier_r <= RST_TX_CARRIER;
            config_r <= RST_CONFIG;
            fe1_r <= RST_FE_SELECT;
            fe2_r <= RST_FE_SELECT;
            fe3_r <= RST_FE_SELECT;
            modCtl_r <= RST_MODULE_CONTROL;
            flags_r <= RST_FLAG_COUNTS; // R2 R4
            bankVal_r <= BANK_SELECT_READ;
            bankSw_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            rxBand_r <= rxBand_nxt;
            txCarrier_r <= txCarrier_nxt;
            config_r <= config_nxt;
            fe1_r <= fe1_nxt;
            fe2_r <= fe2_nxt;
            fe3_r <= fe3_nxt;
            modCtl_r <= modCtl_nxt;
            flags_r <= flags_nxt;
            bankVal_r <= bankVal_nxt;
            bankSw_r <= bankSw_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign regRdata = rdata_r;
    assign bankSwitch = bankSw_r;
    assign bankSelectValue = bankVal_r;
    assign frontEndSelectOne = fe1_r;
    assign frontEndSelectTwo = fe2_r;
    assign frontEndSelectThree = fe3_r;
    assign moduleControl = modCtl_r;
    assign mediumFlagCount = flag_count(flags_r[MEDIUM_LSB +: 4]); // R1
    assign fastFlagCount = flag_count(flags_r[FAST_LSB +: 4]); // R1 R4

    // field view of the three remote registers
    assign cfg = '{codingEn: config_r[CODING_BIT], txHigh: config_r[TX_HIGH_BIT],
                   rxHigh: config_r[RX_HIGH_BIT], modSel: config_r[MOD_LSB +: 2],
                   widthSel: txCarrier_r[RANGE_LSB +: 3], txFreq: txCarrier_r[FREQ_LSB +: 5],
                   rxRange: rxBand_r[RANGE_LSB +: 3], rxFreq: rxBand_r[FREQ_LSB +: 5]};

    // carrier frequency in kHz for the transmit select code; zero when reserved
    function automatic logic [9:0] tx_khz(input logic high, input logic [4:0] code);
        logic [9:0] f;
        f = 10'h000;
        if (high) begin
            unique case (code) // R14
                5'h03: f = 10'h190;
                5'h08: f = 10'h1C2;
                5'h0B: f = 10'h1E0;
                default: f = 10'h000;
            endcase
        end else if (code >= 5'h03 && code <= 5'h1D) begin
            f = 10'(code) + 10'h01B; // R13
        end
        return f;
    endfunction : tx_khz

    // burst width in tenths of a millisecond; zero when reserved
    function automatic logic [6:0] width_tenth_ms(input logic high, input logic [2:0] code);
        logic [6:0] w;
        w = 7'h00;
        unique case (code) // R12
            3'h2: w = high ? 7'h07 : 7'h3C;
            3'h3: w = high ? 7'h08 : 7'h46;
            3'h4: w = high ? 7'h09 : 7'h5A;
            3'h5: w = high ? 7'h0A : 7'h6A;
            default: w = 7'h00;
        endcase
        return w;
    endfunction : width_tenth_ms

    // rx window edges in tenths of kHz: {min, max}; zero when reserved
    function automatic logic [31:0] rx_window(input logic high, input logic [2:0] rng,
                                              input logic [4:0] code);
        logic [15:0] lo, hi;
        lo = 16'h0000;
        hi = 16'h0000;
        if (high) begin
            if (rng == 3'h1) begin
                unique case (code) // R10
                    5'h03: begin lo = 16'd3556; hi = 16'd4571; end
                    5'h08: begin lo = 16'd3801; hi = 16'd4898; end
                    5'h0B: begin lo = 16'd4103; hi = 16'd5274; end
                    default: begin lo = 16'h0000; hi = 16'h0000; end
                endcase
            end else begin
                // ask reception windows around the 500 kHz carrier
                unique case (rng) // R11
                    3'h2: begin lo = 16'd4571; hi = 16'd5647; end
                    3'h3: begin lo = 16'd4364; hi = 16'd6000; end
                    3'h4: begin lo = 16'd4174; hi = 16'd6400; end
                    3'h5: begin lo = 16'd4000; hi = 16'd6856; end
                    3'h6: begin lo = 16'd3840; hi = 16'd7385; end
                    default: begin lo = 16'h0000; hi = 16'h0000; end
                endcase
            end
        end else begin
            // low band: only the narrowest range column listed at full detail
            unique case (code) // R9
                5'h02: begin lo = 16'd261; hi = 16'd296; end
                5'h03: begin lo = 16'd282; hi = 16'd320; end
                5'h04: begin lo = 16'd294; hi = 16'd333; end
                5'h05: begin lo = 16'd300; hi = 16'd340; end
                5'h06: begin lo = 16'd314; hi = 16'd356; end
                5'h07: begin lo = 16'd321; hi = 16'd364; end
                5'h08: begin lo = 16'd328; hi = 16'd372; end
                5'h09: begin lo = 16'd336; hi = 16'd381; end // R8
                5'h0B: begin lo = 16'd344; hi = 16'd390; end
                5'h0C: begin lo = 16'd362; hi = 16'd410; end
                5'h0D: begin lo = 16'd372; hi = 16'd421; end
                5'h0F: begin lo = 16'd382; hi = 16'd432; end
                5'h10: begin lo = 16'd403; hi = 16'd457; end
                5'h12: begin lo = 16'd415; hi = 16'd471; end
                5'h13: begin lo = 16'd428; hi = 16'd485; end
                5'h15: begin lo = 16'd441; hi = 16'd500; end
                5'h17: begin lo = 16'd455; hi = 16'd516; end
                5'h1A: begin lo = 16'd487; hi = 16'd552; end
                5'h1B: begin lo = 16'd504; hi = 16'd571; end
                5'h1D: begin lo = 16'd543; hi = 16'd615; end
                default: begin lo = 16'h0000; hi = 16'h0000; end
            endcase
            // range codes 2 and 3 stretch the window by a fixed fraction; codes 0 and 4-7 give zero
            if (rng == 3'h2 && lo != 16'h0000) begin
                lo = lo - (lo >> 4);
                hi = hi + (hi >> 3);
            end else if (rng == 3'h3 && lo != 16'h0000) begin
                lo = lo - (lo >> 3);
                hi = hi + (hi >> 2);
            end else if (rng != 3'h1) begin
                lo = 16'h0000;
                hi = 16'h0000;
            end
        end
        return {lo, hi};
    endfunction : rx_window

    // divider loads derived from the selected codes
    logic [9:0] txKhz;
    logic [CARRIER_CNT_W-1:0] halfPeriod;
    logic [BURST_CNT_W-1:0] burstLen;
    logic [31:0] win;
    logic [CARRIER_CNT_W+3:0] periodMin, periodMax;
    assign txKhz = tx_khz(cfg.txHigh, cfg.txFreq);
    assign halfPeriod = (txKhz == 10'h000) ? '0 :
        CARRIER_CNT_W'(CLK_KHZ / (2 * int'(txKhz))); // R19
    assign burstLen = BURST_CNT_W'(CLK_KHZ * int'(width_tenth_ms(cfg.txHigh, cfg.widthSel)) / 10);
    assign win = rx_window(cfg.rxHigh, cfg.rxRange, cfg.rxFreq);
    // period limits in clocks: slowest allowed carrier gives the longest period
    assign periodMax = (win[31:16] == 16'h0000) ? '0 :
        (CARRIER_CNT_W+4)'(CLK_KHZ * 10 / int'(win[31:16])); // R20
    assign periodMin = (win[15:0] == 16'h0000) ? '0 :
        (CARRIER_CNT_W+4)'(CLK_KHZ * 10 / int'(win[15:0]));

    // transmitter: carrier toggle, burst timer and pulse counter
    tx_state_t txState_r, txState_nxt;
    logic [CARRIER_CNT_W-1:0] carCnt_r, carCnt_nxt;
    logic [BURST_CNT_W-1:0] burstCnt_r, burstCnt_nxt;
    logic [PULSE_CNT_W-1:0] pulses_r, pulses_nxt;
    logic carrier_r, carrier_nxt, sendBit_r, sendBit_nxt, txOut_r, txOut_nxt;
    logic [PULSE_CNT_W-1:0] pulseLimit;
    logic [7:0] txCfgShadow_r;
    logic cfgChanged;
    assign cfgChanged = txCfgShadow_r != txCarrier_r;
    // reserved modulation code 11 sends nothing in coded mode
    assign pulseLimit = (cfg.modSel == 2'h1) ? 4'h8 : (cfg.modSel == 2'h2) ? 4'h6 : 4'h0; // R17

    always_comb begin
        txState_nxt = txState_r;
        carCnt_nxt = carCnt_r;
        burstCnt_nxt = burstCnt_r;
        pulses_nxt = pulses_r;
        carrier_nxt = carrier_r;
        sendBit_nxt = sendBit_r;
        txOut_nxt = 1'b0;
        unique case (txState_r)
            TX_IDLE: begin
                if (txBitValid && halfPeriod != '0 && burstLen != '0) begin
                    txState_nxt = TX_BURST;
                    sendBit_nxt = txBit;
                    carCnt_nxt = halfPeriod;
                    burstCnt_nxt = burstLen;
                    pulses_nxt = '0;
                    carrier_nxt = 1'b1;
                end
            end
            TX_BURST: begin
                burstCnt_nxt = burstCnt_r - 1'b1;
                if (carCnt_r <= 1 || cfgChanged) begin // R19
                    carCnt_nxt = halfPeriod;
                    carrier_nxt = ~carrier_r;
                    // saturate so a long burst never wraps back below the cap
                    if (carrier_r && pulses_r != '1) begin
                        pulses_nxt = pulses_r + 1'b1;
                    end
                end else begin
                    carCnt_nxt = carCnt_r - 1'b1;
                end
                // coded mode: a 1 is silence, a 0 is a counted or continuous burst
                if (cfg.codingEn) begin // R15 R16
                    txOut_nxt = ~sendBit_r && carrier_r &&
                        (cfg.modSel == 2'h0 || pulses_r < pulseLimit); // R17
                end else begin
                    txOut_nxt = ~sendBit_r && carrier_r;
                end
                if (burstCnt_r <= 1) begin
                    txState_nxt = TX_GAP;
                end
            end
            TX_GAP: begin
                txState_nxt = TX_IDLE;
            end
            default: txState_nxt = TX_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            txState_r <= TX_IDLE;
            carCnt_r <= '0;
            burstCnt_r <= '0;
            pulses_r <= '0;
            carrier_r <= 1'b0;
            sendBit_r <= 1'b1;
            txOut_r <= 1'b0;
            txCfgShadow_r <= RST_TX_CARRIER;
        end else begin
            txState_r <= txState_nxt;
            carCnt_r <= carCnt_nxt;
            burstCnt_r <= burstCnt_nxt;
            pulses_r <= pulses_nxt;
            carrier_r <= carrier_nxt;
            sendBit_r <= sendBit_nxt;
            txOut_r <= txOut_nxt;
            txCfgShadow_r <= txCarrier_r;
        end
    end
    assign irTxPin = txOut_r;

    // receiver: synchronise pin, time rising edges, band-pass check
    logic rxMeta_r, rxSync_r, rxPrev_r, rxBit_r, rxBit_nxt;
    logic [CARRIER_CNT_W+3:0] period_r, period_nxt;
    logic [BURST_CNT_W-1:0] quiet_r, quiet_nxt;
    logic inBand;
    assign inBand = period_r >= periodMin && period_r <= periodMax && periodMax != '0; // R7

    always_comb begin
        period_nxt = period_r;
        quiet_nxt = quiet_r;
        rxBit_nxt = rxBit_r;
        if (rxSync_r && !rxPrev_r) begin
            period_nxt = '0;
            if (inBand) begin // R7 R20
                quiet_nxt = '0;
                rxBit_nxt = 1'b0; // R16
            end
        end else if (period_r != '1) begin
            period_nxt = period_r + 1'b1;
        end
        if (!(rxSync_r && !rxPrev_r && inBand)) begin
            if (quiet_r > {3'h0, periodMax}) begin
                rxBit_nxt = 1'b1; // R16
            end else begin
                quiet_nxt = quiet_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rxMeta_r <= 1'b0;
            rxSync_r <= 1'b0;
            rxPrev_r <= 1'b0;
            period_r <= '1;
            quiet_r <= '0;
            rxBit_r <= 1'b1;
        end else begin
            rxMeta_r <= irRxPin;
            rxSync_r <= rxMeta_r;
            rxPrev_r <= rxSync_r;
            period_r <= period_nxt;
            quiet_r <= quiet_nxt;
            rxBit_r <= rxBit_nxt;
        end
    end
    assign rxBitValue = rxBit_r;

    // checks
    a_bank_select_read: assert property (@(posedge clock) disable iff (rst)
        regRd && regAddr == 4'(OFS_BANK_SELECT) |=> regRdata == 8'hF4) // R18
        else $error("bank select read not F4");
    a_flag_reset_two: assert property (@(posedge clock)
        $fell(rst) |-> mediumFlagCount == 6'h02 && fastFlagCount == 6'h10) // R2
        else $error("flag counts wrong after reset");
    a_flag_decode_map: assert property (@(posedge clock) disable iff (rst)
        flags_r[7:4] == 4'hE |-> mediumFlagCount == 6'h20) // R1
        else $error("flag code E not 32");
    a_fast_preamble_write: assert property (@(posedge clock) disable iff (rst)
        regWr && regAddr == OFS_FLAG_COUNTS && regWdata[3:0] == 4'hA
        |=> fastFlagCount == 6'h10) // R4
        else $error("fast preamble code A not 16");
    a_bank_write_pulse: assert property (@(posedge clock) disable iff (rst)
        bankSwitch == $past(regWr && regAddr == 4'(OFS_BANK_SELECT))) // R18
        else $error("bank switch pulse wrong");
    a_coded_one_silent: assert property (@(posedge clock) disable iff (rst)
        txState_r == TX_BURST && cfg.codingEn && sendBit_r |=> !irTxPin) // R16
        else $error("coded one emitted energy");
    a_eight_pulse_cap: assert property (@(posedge clock) disable iff (rst)
        cfg.codingEn && cfg.modSel == 2'h1 && pulses_r >= 4'h8 |=> !irTxPin) // R17
        else $error("more than eight pulses");
    a_reserved_freq_idle: assert property (@(posedge clock) disable iff (rst)
        txState_r == TX_IDLE && halfPeriod == '0 |=> txState_r == TX_IDLE) // R13
        else $error("burst started on reserved code");
    a_high_carrier_div: assert property (@(posedge clock) disable iff (rst)
        cfg.txHigh && cfg.txFreq == 5'h03 |-> halfPeriod == CARRIER_CNT_W'(CLK_KHZ / 800)) // R14
        else $error("400 kHz divider wrong");
    a_width_load: assert property (@(posedge clock) disable iff (rst)
        !cfg.txHigh && cfg.widthSel == 3'h5 |-> burstLen == BURST_CNT_W'(CLK_KHZ * 106 / 10)) // R12
        else $error("10.6 ms width wrong");
    a_rx_out_band: assert property (@(posedge clock) disable iff (rst)
        rxSync_r && !rxPrev_r && !inBand && rxBit_r && quiet_r > {3'h0, periodMax}
        |=> rxBitValue) // R7
        else $error("out of band edge accepted");
    a_window_reset: assert property (@(posedge clock) disable iff (rst)
        rxBand_r == 8'h29 && !cfg.rxHigh
        |-> periodMin == 14'(CLK_KHZ * 10 / 381) && periodMax == 14'(CLK_KHZ * 10 / 336)) // R8
        else $error("reset window limits wrong");
endmodule : ir_carrier_and_flag_config

// *** tb/ir_front_end_model.sv ***
// transceiver model: carrier source on the receive pin, pulse counter on the transmit pin
module ir_front_end_model (
    // clock
    input wire logic clock,
    // bench control
    input wire logic on,
    input wire logic clr,
    input wire logic [7:0] halfPer,
    // transceiver pins
    input wire logic irTxPin,
    output logic irRxPin,
    output logic [9:0] edges
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_r = 8'h00;
    logic txOld_r = 1'b0;
    initial irRxPin = 1'b0;
    initial edges = 10'h000;
    // square carrier while on, dark line otherwise
    always @(posedge clock) begin
        cnt_r <= (cnt_r + 8'h01 >= halfPer) ? 8'h00 : cnt_r + 8'h01;
        if (!on) irRxPin <= 1'b0;
        else if (cnt_r == 8'h00) irRxPin <= ~irRxPin;
    end
    // count emitted pulses; a one bit must leave the pin dark
    always @(posedge clock) begin
        txOld_r <= irTxPin;
        if (clr) edges <= 10'h000;
        else if (irTxPin && !txOld_r) edges <= edges + 10'h001;
    end
endmodule : ir_front_end_model

// *** tb/ir_carrier_and_flag_config_tb_top.sv ***
// bench: register bank, flag decode, transmit bursts and carrier detection
module ir_carrier_and_flag_config_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, rst = 1, regWr = 0, regRd = 0, txBit = 0, txBitValid = 0;
    logic rdSeen = 0, bsSeen = 0, on = 0, clr = 0, irRxPin, irTxPin, bankSwitch, rxBitValue;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00, regRdata, halfPer = 8'h0E, d;
    logic [7:0] bsv, fe1, fe2, fe3, mc;
    logic [5:0] mediumFlagCount, fastFlagCount;
    logic [9:0] edges;
    logic [7:0] expQ[$];
    int error_cnt = 0, check_count = 0;
    logic [5:0] tbl[16] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08,
                            6'h0A, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h00};
    logic [3:0] ra[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
    logic [7:0] re[6] = '{8'h29, 8'h69, 8'h00, 8'hF4, 8'h2A, 8'h00};
    logic [7:0] txe[4] = '{8'h08, 8'h06, 8'h00, 8'h00};
    always #50 clock = ~clock;
    ir_carrier_and_flag_config #(.CLK_KHZ(1000)) i_ir_carrier_and_flag_config (
        .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .bankSwitch(bankSwitch), .bankSelectValue(bsv),
        .txBit(txBit), .txBitValid(txBitValid), .mediumFlagCount(mediumFlagCount),
        .fastFlagCount(fastFlagCount), .frontEndSelectOne(fe1), .frontEndSelectTwo(fe2),
        .frontEndSelectThree(fe3), .moduleControl(mc), .rxBitValue(rxBitValue),
        .irRxPin(irRxPin), .irTxPin(irTxPin));
    ir_front_end_model i_ir_front_end_model (.clock(clock), .on(on), .clr(clr),
        .halfPer(halfPer), .irTxPin(irTxPin), .irRxPin(irRxPin), .edges(edges));
    task chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // one bus cycle; a read notes its expected data
    task rq(input logic w, input logic r, input logic [3:0] a, input logic [7:0] v);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= v;
        if (r) expQ.push_back(v);
        @(posedge clock);
    endtask : rq
    task idle();
        regWr <= 0;
        regRd <= 0;
        @(posedge clock);
    endtask : idle
    task end_of_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // read data and bank switch pulse stand one cycle after the strobe
    always @(posedge clock) begin
        if (rdSeen) chk(regRdata, expQ.pop_front());
        if (bsSeen) chk({7'h00, bankSwitch}, 8'h01);
        rdSeen <= regRd;
        bsSeen <= regWr && regAddr == 4'h3;
    end
    initial begin
        void'($urandom(32'h5147));
        repeat (20) @(posedge clock);
        rst <= 0;
        for (int i = 0; i < 6; i++) rq(0, 1, ra[i], re[i]);
        chk({2'h0, mediumFlagCount}, 8'h02);
        chk({2'h0, fastFlagCount}, 8'h10);
        chk(bsv, 8'hF4);
        for (int a = 0; a < 8; a++) begin
            d = 8'($urandom);
            rq(1, 0, 4'(a), d);
            rq(0, 1, 4'(a), (a == 3) ? 8'hF4 : d);
            // register contents also reach their outputs
            if (a > 2) chk((a == 3) ? bsv : (a == 4) ? fe1 : (a == 5) ? fe2 :
                (a == 6) ? fe3 : mc, d);
        end
        for (int k = 0; k < 16; k++) begin
            rq(1, 0, 4'h8, {4'(k), 4'(15 - k)});
            idle();
            chk({2'h0, mediumFlagCount}, {2'h0, tbl[k]});
            chk({2'h0, fastFlagCount}, {2'h0, tbl[15 - k]});
        end
        rq(1, 0, 4'h8, 8'h2A);
        rq(1, 0, 4'h0, 8'h29);
        rq(1, 0, 4'h1, 8'h69);
        for (int j = 0; j < 5; j++) begin
            rq(1, 0, 4'h2, (j == 4) ? 8'h00 : {6'h20, 2'((j == 3) ? 1 : j + 1)});
            idle();
            clr <= 1;
            @(posedge clock);
            clr <= 0;
            txBit <= (j == 3);
            txBitValid <= 1;
            @(posedge clock);
            txBitValid <= 0;
            repeat (8000) @(posedge clock);
            if (j < 4) chk(edges[7:0], txe[j]);
            else chk({7'h00, edges > 10'd8}, 8'h01);
        end
        on <= 1;
        repeat (300) @(posedge clock);
        chk({7'h00, rxBitValue}, 8'h00);
        on <= 0;
        repeat (300) @(posedge clock);
        chk({7'h00, rxBitValue}, 8'h01);
        halfPer <= 8'h05;
        on <= 1;
        repeat (300) @(posedge clock);
        chk({7'h00, rxBitValue}, 8'h01);
        end_of_test();
    end
endmodule : ir_carrier_and_flag_config_tb_top
